// [rtl/acc_converter.sv]
/*
 * Converter wrapper: APB registers, channel decode, conversion clock choice,
 * hardware trigger, power-mode gating and the successive approximation sequencer.
 * Assumes an external comparator answers the trial code within one cycle.
 */
`timescale 1ns/1ps
module acc_converter (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extRefTick,
    input wire logic stop3Mode,
    input wire logic compHigh,
    output acc_pkg::acc_mux_s muxSel,
    output logic [9:0] dacCode,
    output logic sampleOn,
    output logic convIrq
);

    ////////////////////////////////////////////////////////////////////////
    // Channel decode helpers
    function automatic logic isGround(input logic [4:0] ch);
        isGround = (ch >= acc_pkg::CH_GND_FIRST) && (ch <= acc_pkg::CH_GND_LAST);
    endfunction

    function automatic logic isPin(input logic [4:0] ch);
        isPin = (ch <= acc_pkg::CH_PIN_LAST);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [4:0] chan_q; // Channel select field
    logic irqEn_q, cont_q, done_q;
    logic hwTrigEn_q, cmpEn_q, cmpGe_q;
    logic [9:0] result_q, cmpVal_q;
    logic lowPower_q, longSample_q, mode10_q;
    acc_pkg::acc_clk_e clkSel_q;
    logic [3:0] pinEn_q; // Sole pin enable register
    logic bandgap_buffer_enable_q, lvse_q;
    logic rtiSrc_q;
    logic [2:0] rtiRate_q;
    logic [31:0] prdata_q;
    acc_pkg::acc_mux_s muxSel_q;

    // Sequencer
    acc_pkg::acc_state_e state_q, state_d;
    logic [4:0] smpCnt_q;
    logic [3:0] bitIdx_q;
    logic [9:0] sar_q;
    logic armed_q; // Continuous run under hardware trigger

    // Clock dividers
    logic halfTog_q, lpTog_q;
    logic [7:0] asyncDiv_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic setup, access, wrEn, rdEn, hit;
    logic wrCtrl1, wrCtrl2, wrCmp, wrCfg, wrPin, wrPwr, wrRti, rdResult;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wrEn = access && pwrite;
    assign rdEn = access && !pwrite;
    // pin registers two and three unmapped
    assign hit = (paddr[1:0] == 2'b00) && (paddr <= acc_pkg::OFF_RTICTL);
    assign wrCtrl1 = wrEn && (paddr == acc_pkg::OFF_CTRL1);
    assign wrCtrl2 = wrEn && (paddr == acc_pkg::OFF_CTRL2);
    assign wrCmp = wrEn && (paddr == acc_pkg::OFF_COMPARE);
    assign wrCfg = wrEn && (paddr == acc_pkg::OFF_CFG);
    assign wrPin = wrEn && (paddr == acc_pkg::OFF_PINEN);
    assign wrPwr = wrEn && (paddr == acc_pkg::OFF_PWR);
    assign wrRti = wrEn && (paddr == acc_pkg::OFF_RTICTL);
    assign rdResult = rdEn && (paddr == acc_pkg::OFF_RESULT);
    assign pready = 1'b1; // Zero wait states
    assign pslverr = access && !hit;
    assign prdata = prdata_q;

    // Read mux, captured in the setup phase
    logic [31:0] rdMux;
    assign rdMux =
        (paddr == acc_pkg::OFF_CTRL1) ? {24'h0, done_q, irqEn_q, cont_q, chan_q} :
        (paddr == acc_pkg::OFF_CTRL2) ?
            {24'h0, state_q != acc_pkg::ST_IDLE, hwTrigEn_q, cmpEn_q, cmpGe_q, 4'h0} :
        (paddr == acc_pkg::OFF_RESULT) ? {22'h0, result_q} :
        (paddr == acc_pkg::OFF_COMPARE) ? {22'h0, cmpVal_q} :
        (paddr == acc_pkg::OFF_CFG) ?
            {24'h0, lowPower_q, 2'b00, longSample_q, 1'b0, mode10_q, clkSel_q} :
        (paddr == acc_pkg::OFF_PINEN) ? {28'h0, pinEn_q} :
        (paddr == acc_pkg::OFF_PWR) ? {30'h0, lvse_q, bandgap_buffer_enable_q} :
        (paddr == acc_pkg::OFF_RTICTL) ? {28'h0, rtiSrc_q, rtiRate_q} : 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // Periodic trigger source
    logic rtiOverflow;
    acc_rti_counter uRti (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .extRefTick(extRefTick),
        .srcSel(rtiSrc_q),
        .rateSel(rtiRate_q),
        .overflow(rtiOverflow)
    );

    ////////////////////////////////////////////////////////////////////////
    // Conversion clock enable
    logic asyncTick, rawTick, convTick, runOk;
    assign asyncTick = (asyncDiv_q == 8'(acc_pkg::ASYNC_DIV - 1));
    assign rawTick = (clkSel_q == acc_pkg::CLK_BUS) ? 1'b1 :
                     (clkSel_q == acc_pkg::CLK_BUS_HALF) ? halfTog_q :
                     (clkSel_q == acc_pkg::CLK_ASYNC) ? asyncTick : 1'b0;
    assign convTick = rawTick && (!lowPower_q || lpTog_q);
    assign runOk = !stop3Mode || lvse_q;

    // Dividers run from reset, so the local clock is always ready
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            halfTog_q <= 1'b0;
            lpTog_q <= 1'b0;
            asyncDiv_q <= 8'h00;
        end else begin
            halfTog_q <= !halfTog_q;
            lpTog_q <= rawTick ? !lpTog_q : lpTog_q;
            asyncDiv_q <= asyncTick ? 8'h00 : asyncDiv_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start, completion and compare
    logic chanOn, swStart, hwStart, lastBit, complete, cmpTrue, doneSet;
    logic [9:0] trial, bitMask, sarNext, formatted, cmpRef;
    logic [4:0] smpLen;
    assign chanOn = (chan_q != acc_pkg::CH_OFF);
    assign swStart = wrCtrl1 && (pwdata[4:0] != acc_pkg::CH_OFF) && !hwTrigEn_q && runOk;
    assign hwStart = hwTrigEn_q && rtiOverflow && chanOn && runOk && !wrCtrl1 &&
                     (state_q == acc_pkg::ST_IDLE);
    assign smpLen = longSample_q ? acc_pkg::SAMPLE_LONG : acc_pkg::SAMPLE_SHORT;
    assign bitMask = 10'h001 << bitIdx_q;
    assign trial = sar_q | bitMask;
    assign sarNext = compHigh ? trial : sar_q;
    assign lastBit = (bitIdx_q == 4'h0);
    assign complete = (state_q == acc_pkg::ST_CONVERT) && convTick && runOk && lastBit;
    assign formatted = mode10_q ? sarNext : {2'b00, sarNext[9:2]};
    assign cmpRef = mode10_q ? cmpVal_q : {2'b00, cmpVal_q[7:0]};
    assign cmpTrue = cmpGe_q ? (formatted >= cmpRef) : (formatted < cmpRef);
    assign doneSet = complete && (!cmpEn_q || cmpTrue);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            acc_pkg::ST_IDLE: begin
                if (swStart || hwStart) begin
                    state_d = acc_pkg::ST_SAMPLE;
                end
            end
            acc_pkg::ST_SAMPLE: begin
                if (convTick && runOk && smpCnt_q == smpLen - 5'h01) begin
                    state_d = acc_pkg::ST_CONVERT;
                end
            end
            acc_pkg::ST_CONVERT: begin
                if (complete) begin
                    state_d = (cont_q && (!hwTrigEn_q || armed_q)) ?
                              acc_pkg::ST_SAMPLE : acc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = acc_pkg::ST_IDLE;
            end
        endcase
        if (wrCtrl1) begin
            state_d = swStart ? acc_pkg::ST_SAMPLE : acc_pkg::ST_IDLE;
        end
    end

    // Sequencer registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= acc_pkg::ST_IDLE;
            smpCnt_q <= 5'h00;
            bitIdx_q <= 4'h9;
            sar_q <= 10'h000;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            armed_q <= wrCtrl1 ? 1'b0 : (hwStart ? 1'b1 : armed_q);
            // a write during sampling restarts the count too
            if (swStart || (state_d == acc_pkg::ST_SAMPLE && state_q != acc_pkg::ST_SAMPLE)) begin
                smpCnt_q <= 5'h00;
            end else if (convTick && runOk) begin
                smpCnt_q <= smpCnt_q + 5'h01;
            end
            if (state_q != acc_pkg::ST_CONVERT) begin
                bitIdx_q <= 4'(acc_pkg::RES_BITS - 1);
                sar_q <= 10'h000;
            end else if (convTick && runOk) begin
                bitIdx_q <= bitIdx_q - 4'h1;
                sar_q <= sarNext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            chan_q <= acc_pkg::CH_RESET;
            {irqEn_q, cont_q, hwTrigEn_q, cmpEn_q, cmpGe_q} <= 5'h00;
            {cmpVal_q, result_q} <= 20'h00000;
            {lowPower_q, longSample_q, mode10_q} <= 3'h0;
            clkSel_q <= acc_pkg::CLK_BUS;
            pinEn_q <= acc_pkg::PINEN_RESET;
            {bandgap_buffer_enable_q, lvse_q, rtiSrc_q} <= 3'h0;
            rtiRate_q <= 3'h0;
        end else begin
            if (wrCtrl1) begin
                {irqEn_q, cont_q, chan_q} <= pwdata[acc_pkg::C1_IRQEN:0];
            end
            if (wrCtrl2) begin
                hwTrigEn_q <= pwdata[acc_pkg::C2_HWT];
                cmpEn_q <= pwdata[acc_pkg::C2_CMPEN];
                cmpGe_q <= pwdata[acc_pkg::C2_CMPGE];
            end
            if (wrCmp) begin
                cmpVal_q <= pwdata[9:0];
            end
            if (wrCfg) begin
                lowPower_q <= pwdata[acc_pkg::CFG_LP];
                longSample_q <= pwdata[acc_pkg::CFG_LONG];
                mode10_q <= pwdata[acc_pkg::CFG_MODE10];
                clkSel_q <= acc_pkg::acc_clk_e'(pwdata[1:0]);
            end
            if (wrPin) begin
                pinEn_q <= pwdata[3:0];
            end
            if (wrPwr) begin
                bandgap_buffer_enable_q <= pwdata[acc_pkg::PWR_BANDGAP_BUFFER_ENABLE];
                lvse_q <= pwdata[acc_pkg::PWR_LVSE];
            end
            if (wrRti) begin
                {rtiSrc_q, rtiRate_q} <= pwdata[acc_pkg::RTI_SRC:0];
            end
            if (complete) begin
                result_q <= formatted;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            done_q <= 1'b0;
        end else begin
            done_q <= doneSet || (done_q && !wrCtrl1 && !rdResult);
        end
    end

    // Read data latched in setup so it is a flop during access
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prdata_q <= 32'h0;
        end else if (setup) begin
            prdata_q <= rdMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog switch decode
    acc_pkg::acc_mux_s muxD;
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : gPin
            assign muxD.pinConnect[p] = (chan_q == 5'(p)) && pinEn_q[p];
        end
    endgenerate
    assign muxD.gndSel = isGround(chan_q);
    assign muxD.tempSel = (chan_q == acc_pkg::CH_TEMP);
    assign muxD.bandgapSel = (chan_q == acc_pkg::CH_BGAP) && bandgap_buffer_enable_q;
    assign muxD.refHighSel = (chan_q == acc_pkg::CH_VREFH_A) || (chan_q == acc_pkg::CH_VREFH_B);
    assign muxD.refLowSel = (chan_q == acc_pkg::CH_VREFL);
    assign muxD.powerOn = chanOn && (state_q != acc_pkg::ST_IDLE);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            muxSel_q <= '0;
        end else begin
            muxSel_q <= muxD;
        end
    end

    assign muxSel = muxSel_q;
    assign dacCode = trial;
    assign sampleOn = (state_q == acc_pkg::ST_SAMPLE);
    assign convIrq = done_q && irqEn_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_ground_codes_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        isGround(chan_q) |=> muxSel_q.gndSel && (muxSel_q.pinConnect == 4'h0))
        else $error("ground code did not ground input");
    chk_pin_enable_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        (isPin(chan_q) && !pinEn_q[chan_q[1:0]]) |=> muxSel_q.pinConnect == 4'h0)
        else $error("disabled pin connected");
    chk_temp_sensor_route: assert property (@(posedge sys_clk) disable iff (!rstn)
        (chan_q == acc_pkg::CH_TEMP) |=> muxSel_q.tempSel && !muxSel_q.gndSel)
        else $error("temperature channel not routed");
    chk_bandgap_needs_buffer: assert property (@(posedge sys_clk) disable iff (!rstn)
        muxSel_q.bandgapSel |-> $past(bandgap_buffer_enable_q) && $past(chan_q) == acc_pkg::CH_BGAP)
        else $error("bandgap routed without buffer");
    chk_alt_clock_dead: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clkSel_q == acc_pkg::CLK_ALT) |-> !convTick)
        else $error("alternate clock produced a tick");
    chk_hw_trigger_start: assert property (@(posedge sys_clk) disable iff (!rstn)
        hwStart |=> state_q == acc_pkg::ST_SAMPLE ##1 sampleOn)
        else $error("trigger did not start sampling");
    chk_stop3_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
        (stop3Mode && !lvse_q && !wrCtrl1) |=> $stable(smpCnt_q) && $stable(sar_q))
        else $error("converter ran in stop3 without low-voltage stop");
    chk_off_code_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
        (chan_q == acc_pkg::CH_OFF) |-> state_q == acc_pkg::ST_IDLE ##1 !muxSel_q.powerOn)
        else $error("converter active on off code");
    chk_write_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        swStart |=> state_q == acc_pkg::ST_SAMPLE && smpCnt_q == 5'h00)
        else $error("control write did not restart");
    chk_done_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
        ((wrCtrl1 || rdResult) && !doneSet) |=> !done_q && !convIrq)
        else $error("done flag survived clear");
    chk_single_returns: assert property (@(posedge sys_clk) disable iff (!rstn)
        (complete && !cont_q && !wrCtrl1) |=> state_q == acc_pkg::ST_IDLE)
        else $error("single conversion did not return idle");

    cov_single_done: cover property (@(posedge sys_clk) disable iff (!rstn)
        complete && !cont_q);
    cov_hw_started: cover property (@(posedge sys_clk) disable iff (!rstn) hwStart);
    cov_compare_hit: cover property (@(posedge sys_clk) disable iff (!rstn)
        doneSet && cmpEn_q);

endmodule

// [rtl/acc_pkg.sv]
/*
 * Shared constants and types for the converter channel, clock and trigger wrapper.
 * Assumes a single 100 MHz system clock and a 32-bit APB register bus.
 */
package acc_pkg;

    // Clock and time base
    localparam int unsigned SYS_HZ = 100000000;
    localparam int unsigned SYS_PERIOD_NS = 10;
    localparam int unsigned LF_HZ = 32000;
    localparam int unsigned LF_DIV = SYS_HZ / LF_HZ;
    localparam int unsigned ASYNC_PERIOD_NS = 500;
    localparam int unsigned ASYNC_DIV = ASYNC_PERIOD_NS / SYS_PERIOD_NS;

    // Sample phase lengths in conversion clock ticks
    localparam logic [4:0] SAMPLE_SHORT = 5'h04;
    localparam logic [4:0] SAMPLE_LONG = 5'h18;
    localparam int unsigned RES_BITS = 10;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_RESULT = 8'h08;
    localparam logic [7:0] OFF_COMPARE = 8'h0c;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [7:0] OFF_PINEN = 8'h14;
    localparam logic [7:0] OFF_PWR = 8'h18;
    localparam logic [7:0] OFF_RTICTL = 8'h1c;

    // Field positions
    localparam int unsigned C1_DONE = 7;
    localparam int unsigned C1_IRQEN = 6;
    localparam int unsigned C1_CONT = 5;
    localparam int unsigned C2_ACT = 7;
    localparam int unsigned C2_HWT = 6;
    localparam int unsigned C2_CMPEN = 5;
    localparam int unsigned C2_CMPGE = 4;
    localparam int unsigned CFG_LP = 7;
    localparam int unsigned CFG_LONG = 4;
    localparam int unsigned CFG_MODE10 = 2;
    localparam int unsigned PWR_BANDGAP_BUFFER_ENABLE = 0;
    localparam int unsigned PWR_LVSE = 1;
    localparam int unsigned RTI_SRC = 3;

    // Reset values
    localparam logic [4:0] CH_RESET = 5'h1f;
    localparam logic [3:0] PINEN_RESET = 4'h0;

    // Channel codes
    localparam logic [4:0] CH_PIN_LAST = 5'h03;
    localparam logic [4:0] CH_GND_FIRST = 5'h04;
    localparam logic [4:0] CH_GND_LAST = 5'h15;
    localparam logic [4:0] CH_TEMP = 5'h1a;
    localparam logic [4:0] CH_BGAP = 5'h1b;
    localparam logic [4:0] CH_VREFH_A = 5'h1c;
    localparam logic [4:0] CH_VREFH_B = 5'h1d;
    localparam logic [4:0] CH_VREFL = 5'h1e;
    localparam logic [4:0] CH_OFF = 5'h1f;

    // Periodic counter: overflow after (8 << rate) source ticks
    localparam logic [15:0] RTI_BASE = 16'h0008;

    // Conversion clock sources
    typedef enum logic [1:0] {CLK_BUS, CLK_BUS_HALF, CLK_ALT, CLK_ASYNC} acc_clk_e;

    // Converter sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_state_e;

    // Analog input switch controls
    typedef struct packed {
        logic powerOn;
        logic [3:0] pinConnect;
        logic gndSel;
        logic tempSel;
        logic bandgapSel;
        logic refHighSel;
        logic refLowSel;
    } acc_mux_s;

endpackage

// [rtl/acc_rti_counter.sv]
/*
 * Free-running periodic counter that issues the hardware conversion trigger.
 * Assumes the external reference arrives as a one-cycle enable pulse on sys_clk.
 */
`timescale 1ns/1ps
module acc_rti_counter (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic extRefTick,
    input wire logic srcSel,
    input wire logic [2:0] rateSel,
    output logic overflow
);

    logic [11:0] lfDiv_q; // Internal 32 kHz divider
    logic lfTick;
    logic srcTick;
    logic [15:0] cnt_q;
    logic [15:0] period;
    logic wrap;
    logic overflow_q;

    assign lfTick = (lfDiv_q == 12'(acc_pkg::LF_DIV - 1));
    assign srcTick = srcSel ? extRefTick : lfTick;
    assign period = acc_pkg::RTI_BASE << rateSel;
    assign wrap = srcTick && (cnt_q >= period - 16'h0001);
    assign overflow = overflow_q;

    ////////////////////////////////////////////////////////////////////////
    // Internal low-frequency source, always running
    always_ff @(posedge sys_clk) begin
        if (!rstn || lfTick) begin
            lfDiv_q <= 12'h000;
        end else begin
            lfDiv_q <= lfDiv_q + 12'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // free count, overflow
    // Runs in every power mode, so triggers reach the converter in stop too
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_q <= 16'h0000;
            overflow_q <= 1'b0;
        end else begin
            overflow_q <= wrap;
            if (wrap) begin
                cnt_q <= 16'h0000;
            end else if (srcTick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end

    chk_rti_one_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
        overflow |=> !overflow) else $error("trigger pulse longer than one cycle");

endmodule

// [tb/acc_analog_model.sv]
/* Far side of the converter: analog levels answering each trial code.
   Assumes dacCode and muxSel come from the converter on sys_clk. */
`timescale 1ns/1ps
module acc_analog_model (
    input wire logic sys_clk,
    input wire acc_pkg::acc_mux_s muxSel,
    input wire logic [9:0] dacCode,
    input wire logic [9:0] pinLevel,
    input wire logic tickEn,
    output logic compHigh,
    output logic extRefTick
);
    logic [9:0] level; // Level at the converter input
    logic [3:0] tickCnt = 4'h0; // Reference tick divider
    logic junk = 1'b0; // Floating node, toggles each cycle
    logic srcOn; // Some source switch closed
    ////////////////////////////////////////////////////////////////
    // Open input wanders rather than holding a lucky value
    assign srcOn = |muxSel.pinConnect || muxSel.tempSel || muxSel.bandgapSel;
    assign level = (muxSel.gndSel || muxSel.refLowSel) ? 10'h000 :
        muxSel.refHighSel ? 10'h3ff : srcOn ? pinLevel : {10{junk}};
    assign compHigh = level >= dacCode;
    assign extRefTick = tickEn && tickCnt == 4'h0;
    // Tick every 16 cycles while enabled
    always_ff @(posedge sys_clk) begin
        junk <= ~junk;
        tickCnt <= tickCnt + 4'h1;
    end
endmodule

// [tb/adc_channel_trigger_config_tb_top.sv]
/* Self-checking bench: APB master, random channels, corner cases.
   Assumes the analog model drives the comparator input. */
`timescale 1ns/1ps
module adc_channel_trigger_config_tb_top;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic stop3Mode = 0, tickEn = 0, err, m10, pready, pslverr;
    logic compHigh, extRefTick, sampleOn, convIrq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [9:0] dacCode, level = 10'h000;
    logic [4:0] ch;
    acc_pkg::acc_mux_s muxSel;
    int failures = 0, n_compared = 0, cycles = 0, x;
    acc_converter i_dut (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extRefTick(extRefTick), .stop3Mode(stop3Mode),
        .compHigh(compHigh), .muxSel(muxSel), .dacCode(dacCode), .sampleOn(sampleOn),
        .convIrq(convIrq));
    acc_analog_model i_model (.sys_clk(sys_clk), .muxSel(muxSel), .dacCode(dacCode),
        .pinLevel(level), .tickEn(tickEn), .compHigh(compHigh), .extRefTick(extRefTick));
    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Poll done flag, bounded
    task waitDone(input int n);
        for (int i = 0; i < n; i++) begin
            apb(0, 8'h00, 0);
            if (rd[7] === 1'b1) break;
        end
    endtask
    // Pins and internal sources give the level, ground gives zero
    function logic [31:0] expRes(logic [4:0] c, logic [9:0] v, logic m);
        logic [9:0] r;
        r = (c <= 5'h03 || c >= 5'h1a) ? v : 10'h000;
        return m ? {22'h0, r} : {24'h0, r[9:2]};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h50dbf0ff));
        repeat (10) @(posedge sys_clk);
        rstn <= 1;
        apb(0, 8'h00, 0); chk(rd, 32'h1f);
        apb(0, 8'h14, 0); chk(rd, 32'h0);
        apb(0, 8'h20, 0); chk({31'h0, err}, 32'h1);
        $display("test reset done");
        apb(1, 8'h14, 32'hf); apb(1, 8'h18, 32'h1);
        repeat (10) begin
            x = $urandom % 24;
            ch = 5'(x < 22 ? x : x + 4);
            level <= 10'($urandom);
            m10 = 1'($urandom);
            apb(1, 8'h10, {29'h0, m10, 1'b0, ch[0]});
            apb(1, 8'h00, {24'h0, 3'h2, ch});
            waitDone(40);
            chk({31'h0, convIrq}, 32'h1);
            apb(0, 8'h08, 0); chk(rd, expRes(ch, level, m10));
            apb(0, 8'h00, 0); chk(rd[7:0], {3'h2, ch});
        end
        // temperature: long sample, 2 MHz local clock halved by low power
        level <= 10'h2a5;
        apb(1, 8'h10, 32'h97);
        apb(1, 8'h00, 32'h1a); waitDone(1500);
        apb(0, 8'h08, 0); chk(rd, 32'h2a5);
        $display("test channels done");
        // Compare: 0x100 >= 0x200 fails, less-than holds
        level <= 10'h100;
        apb(1, 8'h10, 32'h4); apb(1, 8'h0c, 32'h200); apb(1, 8'h04, 32'h30);
        apb(1, 8'h00, 32'h1); repeat (40) @(posedge sys_clk);
        apb(0, 8'h00, 0); chk(rd[7], 1'b0);
        apb(1, 8'h04, 32'h20); apb(1, 8'h00, 32'h1); waitDone(40);
        chk(rd[7], 1'b1);
        apb(1, 8'h04, 32'h0); apb(1, 8'h00, 32'h21); waitDone(40);
        chk(rd[7], 1'b1);
        apb(1, 8'h00, 32'h3f); repeat (40) @(posedge sys_clk);
        apb(0, 8'h04, 0); chk(rd[7], 1'b0);
        apb(0, 8'h00, 0); chk(rd[7], 1'b0);
        // Alternate clock never ticks
        apb(1, 8'h10, 32'h6); apb(1, 8'h00, 32'h1); repeat (40) @(posedge sys_clk);
        apb(0, 8'h00, 0); chk(rd[7], 1'b0);
        // Stuck in sampling with pin one switched in
        chk({31'h0, sampleOn}, 32'h1);
        chk({22'h0, muxSel}, 32'h240);
        apb(1, 8'h10, 32'h4);
        stop3Mode <= 1;
        apb(1, 8'h00, 32'h1); repeat (40) @(posedge sys_clk);
        apb(0, 8'h00, 0); chk(rd[7], 1'b0);
        apb(1, 8'h18, 32'h3); apb(1, 8'h00, 32'h1); waitDone(40);
        chk(rd[7], 1'b1);
        $display("test modes done");
        // Hardware trigger from reference ticks, still in stop3
        tickEn <= 1;
        apb(1, 8'h1c, 32'h8); apb(1, 8'h04, 32'h40); apb(1, 8'h00, 32'h1);
        waitDone(100); chk(rd[7], 1'b1);
        $display("test trigger done");
        give_verdict();
    end
endmodule
